// [include/ctt_pkg.sv]
package ctt_pkg;

  // Register offsets
  localparam logic [11:0] CSR_OFFSET    = 12'h010;
  localparam logic [11:0] RELOAD_OFFSET = 12'h014;
  localparam logic [11:0] CURRENT_OFFSET = 12'h018;
  localparam logic [11:0] CALIB_OFFSET  = 12'h01C;

  // Control and status field positions
  localparam int CSR_ENABLE_BIT   = 0;
  localparam int CSR_IRQ_EN_BIT   = 1;
  localparam int CSR_CLK_SEL_BIT  = 2;
  localparam int CSR_WRAPPED_BIT  = 16;

  // Calibration field positions
  localparam int CALIB_IMPRECISE_BIT = 30;
  localparam int CALIB_NO_REF_BIT    = 31;

  // Counter width and reset values
  localparam int          COUNT_W       = 24;
  localparam logic [23:0] COUNT_RESET   = 24'h000000;
  localparam logic [23:0] RELOAD_RESET  = 24'h000000;
  localparam logic [23:0] COUNT_ONE     = 24'h000001;
  localparam logic [31:0] READ_ZERO     = 32'h00000000;

  // Reference clock divide ratio in CPU cycles
  localparam int          REF_DIV_RATIO = 2;
  localparam logic [0:0]  REF_DIV_LAST  = 1'(REF_DIV_RATIO - 1);

  // Register access request from the core
  typedef struct packed {
    logic        req;
    logic        we;
    logic [11:0] addr;
    logic [31:0] wdata;
  } ctt_bus_req_t;

  // Register access answer to the core
  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } ctt_bus_rsp_t;

  // Calibration word from the configuration block
  typedef struct packed {
    logic        no_reference_clock;
    logic        calib_imprecise;
    logic [23:0] ten_ms_calibration;
  } ctt_calib_t;

endpackage : ctt_pkg

// [src/ctt_ref_div.sv]
`timescale 1ns/1ps

// Reference tick enable at half the CPU clock rate
module ctt_ref_div (
  // Clock and reset
  input  logic clk,
  input  logic rst,
  // Tick enable
  output logic tick
);

  logic [0:0] div_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      div_reg <= '0;
    end else if (div_reg == ctt_pkg::REF_DIV_LAST) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  assign tick = (div_reg == ctt_pkg::REF_DIV_LAST);

endmodule : ctt_ref_div

// [src/ctt_edge_sync.sv]
`timescale 1ns/1ps

// Two-stage synchroniser with rising edge pulse
module ctt_edge_sync (
  // Clock and reset
  input  logic clk,
  input  logic rst,
  // Asynchronous level in
  input  logic level_in,
  // One-cycle pulse per rising edge
  output logic rise
);

  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= level_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign rise = sync_reg & ~prev_reg;

endmodule : ctt_edge_sync

// [src/ctt_timer.sv]
`timescale 1ns/1ps

module ctt_timer (
  // Clock and reset
  input  logic                clk,
  input  logic                rst,
  // Register access from the core
  input  ctt_pkg::ctt_bus_req_t bus_req,
  output ctt_pkg::ctt_bus_rsp_t bus_rsp,
  // Calibration source from the configuration block
  input  ctt_pkg::ctt_calib_t calib_src,
  // Tick clock divider output
  input  logic                tick_div_clk,
  // Tick interrupt
  output logic                tick_irq
);

  // Control state
  logic                         counter_enable_reg;
  logic                         tick_irq_enable_reg;
  logic                         count_clock_select_reg;
  logic                         wrapped_flag_reg;
  logic [ctt_pkg::COUNT_W-1:0]  reload_reg;
  logic [ctt_pkg::COUNT_W-1:0]  count_reg;
  logic [ctt_pkg::COUNT_W-1:0]  count_next;
  logic [ctt_pkg::COUNT_W-1:0]  ten_ms_calibration_reg;
  logic                         calib_imprecise_reg;
  logic                         no_reference_clock_reg;
  logic                         irq_reg;
  logic                         ack_reg;
  logic [31:0]                  rdata_reg;

  // Decoded accesses
  logic                         sel_csr;
  logic                         sel_reload;
  logic                         sel_current;
  logic                         wr_csr;
  logic                         wr_reload;
  logic                         wr_current;
  logic                         rd_csr;

  // Tick sources
  logic                         half_tick;
  logic                         div_rise;
  logic                         ref_tick;
  logic                         count_tick;
  logic                         reach_zero;
  logic                         at_zero;
  logic                         at_one;
  logic                         count_load;
  logic                         count_dec;
  logic                         irq_fire;
  logic                         flag_clear;

  // Reads of the live registers
  logic [31:0]                  csr_view;
  logic [31:0]                  reload_view;
  logic [31:0]                  current_view;
  logic [31:0]                  calib_view;
  logic [31:0]                  rdata_next;

  // Internal half-rate reference tick
  ctt_ref_div u_ref_div (
    .clk  (clk),
    .rst  (rst),
    .tick (half_tick)
  );

  // Divider output brought into the CPU clock domain
  ctt_edge_sync u_div_sync (
    .clk      (clk),
    .rst      (rst),
    .level_in (tick_div_clk),
    .rise     (div_rise)
  );

  // Address decode
  assign sel_csr     = bus_req.addr == ctt_pkg::CSR_OFFSET;
  assign sel_reload  = bus_req.addr == ctt_pkg::RELOAD_OFFSET;
  assign sel_current = bus_req.addr == ctt_pkg::CURRENT_OFFSET;

  assign wr_csr     = bus_req.req & bus_req.we & sel_csr;
  assign wr_reload  = bus_req.req & bus_req.we & sel_reload;
  assign wr_current = bus_req.req & bus_req.we & sel_current;
  assign rd_csr     = bus_req.req & ~bus_req.we & sel_csr;

  // Reference tick: divider edge, or half rate when no divider exists
  always_comb begin
    if (no_reference_clock_reg) begin
      ref_tick = half_tick;
    end else begin
      ref_tick = div_rise;
    end
  end

  // Clock select and enable gate the count tick
  always_comb begin
    if (!counter_enable_reg) begin
      count_tick = 1'b0;
    end else if (count_clock_select_reg) begin
      count_tick = 1'b1;
    end else begin
      count_tick = ref_tick;
    end
  end

  // Count events; a write to current value beats any tick
  assign at_zero    = count_reg == ctt_pkg::COUNT_RESET;
  assign at_one     = count_reg == ctt_pkg::COUNT_ONE;
  assign count_load = count_tick & ~wr_current & at_zero;
  assign count_dec  = count_tick & ~wr_current & ~at_zero;
  assign reach_zero = count_tick & ~wr_current & at_one;
  assign irq_fire   = reach_zero & tick_irq_enable_reg;
  assign flag_clear = rd_csr | wr_current;

  // Next count value
  always_comb begin
    count_next = count_reg;
    if (wr_current) begin
      count_next = ctt_pkg::COUNT_RESET;
    end else if (count_load) begin
      count_next = reload_reg;
    end else if (count_dec) begin
      count_next = count_reg - ctt_pkg::COUNT_ONE;
    end
  end

  // Counter
  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= ctt_pkg::COUNT_RESET;
    end else begin
      count_reg <= count_next;
    end
  end

  // Counter enable
  always_ff @(posedge clk) begin
    if (rst) begin
      counter_enable_reg <= 1'b0;
    end else if (wr_csr) begin
      counter_enable_reg <= bus_req.wdata[ctt_pkg::CSR_ENABLE_BIT];
    end
  end

  // Interrupt enable
  always_ff @(posedge clk) begin
    if (rst) begin
      tick_irq_enable_reg <= 1'b0;
    end else if (wr_csr) begin
      tick_irq_enable_reg <= bus_req.wdata[ctt_pkg::CSR_IRQ_EN_BIT];
    end
  end

  // Count clock select
  always_ff @(posedge clk) begin
    if (rst) begin
      count_clock_select_reg <= 1'b0;
    end else if (wr_csr) begin
      count_clock_select_reg <= bus_req.wdata[ctt_pkg::CSR_CLK_SEL_BIT];
    end
  end

  // Reload value
  always_ff @(posedge clk) begin
    if (rst) begin
      reload_reg <= ctt_pkg::RELOAD_RESET;
    end else if (wr_reload) begin
      reload_reg <= bus_req.wdata[ctt_pkg::COUNT_W-1:0];
    end
  end

  // Wrapped flag: a new wrap wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      wrapped_flag_reg <= 1'b0;
    end else if (reach_zero) begin
      wrapped_flag_reg <= 1'b1;
    end else if (flag_clear) begin
      wrapped_flag_reg <= 1'b0;
    end
  end

  // Tick interrupt pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_fire;
    end
  end

  assign tick_irq = irq_reg;

  // Ten-millisecond value from the configuration block
  always_ff @(posedge clk) begin
    if (rst) begin
      ten_ms_calibration_reg <= ctt_pkg::COUNT_RESET;
    end else begin
      ten_ms_calibration_reg <= calib_src.ten_ms_calibration;
    end
  end

  // Precision marker from the configuration block
  always_ff @(posedge clk) begin
    if (rst) begin
      calib_imprecise_reg <= 1'b0;
    end else begin
      calib_imprecise_reg <= calib_src.calib_imprecise;
    end
  end

  // Reference clock presence from the configuration block
  always_ff @(posedge clk) begin
    if (rst) begin
      no_reference_clock_reg <= 1'b0;
    end else begin
      no_reference_clock_reg <= calib_src.no_reference_clock;
    end
  end

  // Register views; reserved bits read as zero
  always_comb begin
    csr_view = ctt_pkg::READ_ZERO;
    csr_view[ctt_pkg::CSR_ENABLE_BIT]  = counter_enable_reg;
    csr_view[ctt_pkg::CSR_IRQ_EN_BIT]  = tick_irq_enable_reg;
    csr_view[ctt_pkg::CSR_CLK_SEL_BIT] = count_clock_select_reg;
    csr_view[ctt_pkg::CSR_WRAPPED_BIT] = wrapped_flag_reg;
  end

  always_comb begin
    reload_view = ctt_pkg::READ_ZERO;
    reload_view[ctt_pkg::COUNT_W-1:0] = reload_reg;
  end

  always_comb begin
    current_view = ctt_pkg::READ_ZERO;
    current_view[ctt_pkg::COUNT_W-1:0] = count_reg;
  end

  always_comb begin
    calib_view = ctt_pkg::READ_ZERO;
    calib_view[ctt_pkg::COUNT_W-1:0] = ten_ms_calibration_reg;
    calib_view[ctt_pkg::CALIB_IMPRECISE_BIT] = calib_imprecise_reg;
    calib_view[ctt_pkg::CALIB_NO_REF_BIT] = no_reference_clock_reg;
  end

  // Read data mux; unmapped addresses read zero
  always_comb begin
    case (bus_req.addr)
      ctt_pkg::CSR_OFFSET: begin
        rdata_next = csr_view;
      end
      ctt_pkg::RELOAD_OFFSET: begin
        rdata_next = reload_view;
      end
      ctt_pkg::CURRENT_OFFSET: begin
        rdata_next = current_view;
      end
      ctt_pkg::CALIB_OFFSET: begin
        rdata_next = calib_view;
      end
      default: begin
        rdata_next = ctt_pkg::READ_ZERO;
      end
    endcase
  end

  // Answer one cycle after the request
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req.req;
    end
  end

  // Read data stands only with the answer to a read
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= ctt_pkg::READ_ZERO;
    end else if (bus_req.req && !bus_req.we) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= ctt_pkg::READ_ZERO;
    end
  end

  always_comb begin
    bus_rsp.ack   = ack_reg;
    bus_rsp.rdata = rdata_reg;
  end

endmodule : ctt_timer

// [tb/ctt_core_model.sv]
`timescale 1ns/1ps
// Core side of the register port
module ctt_core_model (
  // Clock
  input  logic                  clk,
  // Register port
  output ctt_pkg::ctt_bus_req_t bus_req,
  input  ctt_pkg::ctt_bus_rsp_t bus_rsp
);
  initial bus_req = '0;
  // One access: request for one cycle, answer taken in the next
  task automatic acc(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(negedge clk);
    bus_req = '{1'b1, w, a, d};
    @(negedge clk);
    bus_req = '{1'b0, ~w, ~a, ~d};
    q = (bus_rsp.ack === 1'b1) ? bus_rsp.rdata : 'x;
  endtask : acc
endmodule : ctt_core_model

// [tb/ctt_timer_props.sv]
`timescale 1ns/1ps
// Port checks for the tick timer
module ctt_timer_props (
  // Clock and reset
  input logic                  clk,
  input logic                  rst,
  // Register port
  input ctt_pkg::ctt_bus_req_t bus_req,
  input ctt_pkg::ctt_bus_rsp_t bus_rsp,
  // Other inputs and interrupt
  input ctt_pkg::ctt_calib_t   calib_src,
  input logic                  tick_div_clk,
  input logic                  tick_irq
);
  logic [1:0] ctl_sh;
  // Shadow of enable and interrupt enable
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_sh <= 2'h0;
    end else if (bus_req.req && bus_req.we
                 && bus_req.addr == ctt_pkg::CSR_OFFSET) begin
      ctl_sh <= bus_req.wdata[1:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_rd(a);
    bus_req.req && !bus_req.we && bus_req.addr == a;
  endsequence
  sequence s_cur_wr;
    bus_req.req && bus_req.we && bus_req.addr == ctt_pkg::CURRENT_OFFSET;
  endsequence
  property p_ack;
    bus_req.req |=> bus_rsp.ack;
  endproperty
  a_ack: assert property (p_ack) else $error("missing ack");
  property p_no_ack;
    !bus_req.req |=> !bus_rsp.ack;
  endproperty
  a_no_ack: assert property (p_no_ack) else $error("stray ack");
  property p_idle;
    !bus_rsp.ack |-> bus_rsp.rdata == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("data off ack");
  property p_calib;
    s_rd(ctt_pkg::CALIB_OFFSET) ##0 $stable(calib_src) ##0 !$past(rst)
      |=> bus_rsp.rdata == {$past(calib_src[25:24]), 6'h00,
                            $past(calib_src[23:0])};
  endproperty
  a_calib: assert property (p_calib) else $error("bad calib");
  property p_irq_en;
    tick_irq |-> $past(ctl_sh) == 2'h3;
  endproperty
  a_irq_en: assert property (p_irq_en) else $error("irq off");
  property p_irq_pulse;
    tick_irq |=> !tick_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("long irq");
  property p_reset;
    disable iff (1'b0) rst |=> !tick_irq && !bus_rsp.ack;
  endproperty
  a_reset: assert property (p_reset) else $error("busy in reset");
  property p_cur_clr;
    s_cur_wr ##2 s_rd(ctt_pkg::CSR_OFFSET) |=> !bus_rsp.rdata[16];
  endproperty
  a_cur_clr: assert property (p_cur_clr) else $error("flag kept");
endmodule : ctt_timer_props
bind ctt_timer ctt_timer_props u_props (.clk(clk), .rst(rst),
  .bus_req(bus_req), .bus_rsp(bus_rsp), .calib_src(calib_src),
  .tick_div_clk(tick_div_clk), .tick_irq(tick_irq));

// [tb/ctt_timer_tb.sv]
`timescale 1ns/1ps
// Self-checking bench for the tick timer
module ctt_timer_tb;
  localparam logic [11:0] CS = ctt_pkg::CSR_OFFSET;
  localparam logic [11:0] RL = ctt_pkg::RELOAD_OFFSET;
  localparam logic [11:0] CU = ctt_pkg::CURRENT_OFFSET;
  localparam logic [11:0] CA = ctt_pkg::CALIB_OFFSET;
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  div_clk = 1'b0;
  logic                  div_on = 1'b0;
  logic                  irq;
  ctt_pkg::ctt_bus_req_t req;
  ctt_pkg::ctt_bus_rsp_t rsp;
  ctt_pkg::ctt_calib_t   cal = '0;
  logic [31:0]           q;
  logic [23:0]           r;
  int seed = 32'hAAB81026;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  int last = 0;
  int gap = 0;
  int nirq = 0;
  int t;
  always #50 clk = ~clk;
  // Divider output, eight CPU cycles a period, still when off
  always begin
    repeat (4) @(negedge clk);
    div_clk = div_on ? ~div_clk : 1'b0;
  end
  // Interrupt spacing monitor
  always @(negedge clk) begin
    cyc++;
    if (irq === 1'b1) begin
      gap = cyc - last;
      last = cyc;
      nirq++;
    end
  end
  ctt_timer DUT (.clk(clk), .rst(rst), .bus_req(req), .bus_rsp(rsp),
    .calib_src(cal), .tick_div_clk(div_clk), .tick_irq(irq));
  ctt_core_model core (.clk(clk), .bus_req(req), .bus_rsp(rsp));
  function automatic logic [31:0] cal_word(input ctt_pkg::ctt_calib_t c);
    return {c.no_reference_clock, c.calib_imprecise, 6'h00,
            c.ten_ms_calibration};
  endfunction : cal_word
  function automatic int period(input logic [23:0] rv, input int div);
    return (int'(rv) + 1) * div;
  endfunction : period
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    core.acc(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    core.acc(1'b1, a, d, q);
  endtask : wr
  task automatic wait_irq(input int k);
    int t0;
    t0 = nirq;
    for (int i = 0; i < 2000 && nirq < t0 + k; i++) @(negedge clk);
    if (nirq < t0 + k) begin
      err_total++;
      $display("unexpected at %0t: interrupt missing", $time);
    end
  endtask : wait_irq
  task results;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    rd(CS, 32'h0);
    rd(RL, 32'h0);
    rd(CU, 32'h0);
    rd(CA, 32'h0);
    rd(12'h020, 32'h0);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      cal = {i[1:0], 24'($random(seed))};
      wr(CA, 32'hFFFFFFFF);
      rd(CA, cal_word(cal));
    end
    r = 24'($random(seed));
    wr(RL, {8'h00, r});
    rd(RL, {8'h00, r});
    $display("register test done");
    r = 24'h2 + 24'($random(seed) & 7);
    wr(RL, {8'h00, r});
    wr(CU, 32'h0);
    wr(CS, 32'h7);
    wait_irq(2);
    chk(gap, period(r, 1));
    wr(CS, 32'h0);
    rd(CS, 32'h00010000);
    rd(CS, 32'h0);
    core.acc(1'b0, CU, 32'h0, q);
    rd(CU, q);
    chk({31'h0, (q <= {8'h00, r})}, 32'h1);
    $display("count test done");
    t = nirq;
    wr(CS, 32'h5);
    repeat (3 * period(r, 1)) @(negedge clk);
    wr(CS, 32'h0);
    chk(nirq, t);
    wr(CU, 32'h0);
    rd(CS, 32'h0);
    rd(CU, 32'h0);
    $display("quiet test done");
    cal = {2'b00, 24'($random(seed))};
    div_on = 1'b1;
    wr(CU, 32'h0);
    wr(CS, 32'h3);
    wait_irq(2);
    chk(gap, period(r, 8));
    cal[25] = 1'b1;
    wait_irq(2);
    chk(gap, period(r, 2));
    wr(CS, 32'h0);
    div_on = 1'b0;
    $display("reference test done");
    wr(CS, 32'h7);
    repeat (8) @(negedge clk);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    rd(CS, 32'h0);
    rd(RL, 32'h0);
    rd(CU, 32'h0);
    $display("restart test done");
    results;
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(negedge clk);
    err_total++;
    results;
  end
endmodule : ctt_timer_tb
